// >>> core/wckb_pkg.sv
// Package of constants and carriers for the wide classifier key builder
package wckb_pkg;
  localparam int PORT_W = 6;
  localparam int GIDX_W = 12;
  localparam int BITMAP_W = 53;
  localparam int DMAC_W = 48;
  localparam int AV_ADDR_W = 4;

  // Key subtype codes
  localparam logic [1:0] KEY_FULL_LINK_LAYER = 2'h0;
  localparam logic [1:0] KEY_NORMAL = 2'h1;
  localparam logic [1:0] KEY_IPV4_FIVE_TUPLE = 2'h2;
  localparam logic [1:0] KEY_CUSTOM_PAYLOAD = 2'h3;

  // Port mask modes
  localparam logic [1:0] MASK_MODE_DEFAULT = 2'h0;
  localparam logic [1:0] MASK_MODE_LOOPED = 2'h1;
  localparam logic [1:0] MASK_MODE_MASQ = 2'h2;
  localparam logic [1:0] MASK_MODE_SPECIAL = 2'h3;

  // Next index control codes of the previous action
  localparam logic [1:0] NXT_CTRL_NONE = 2'h0;
  localparam logic [1:0] NXT_CTRL_VALUE = 2'h1;
  localparam logic [1:0] NXT_CTRL_SERVICE = 2'h2;

  // Generic index default selections
  localparam logic [1:0] GIDX_DEF_ZERO = 2'h0;
  localparam logic [1:0] GIDX_DEF_LPORT = 2'h1;
  localparam logic [1:0] GIDX_DEF_MASQ = 2'h2;

  // Special physical source port numbers and the masquerade inject action code
  localparam logic [5:0] PORT_CPU_ZERO = 6'h35;
  localparam logic [5:0] PORT_CPU_ONE = 6'h36;
  localparam logic [5:0] PORT_VDEV_ZERO = 6'h37;
  localparam logic [5:0] PORT_VDEV_ONE = 6'h38;
  localparam logic [2:0] MASQ_INJECT_ACTION = 3'h5;

  // Mode 3 bitmap field positions
  localparam int BM_CPU_PORT_ZERO_BIT = 0;
  localparam int BM_CPU_PORT_ONE_BIT = 1;
  localparam int BM_VD0_BIT = 2;
  localparam int BM_VD1_BIT = 3;
  localparam int BM_SRC_LSB = 4;
  localparam int BM_PT_LSB = 44;
  localparam int BM_ACT_LSB = 49;

  // Bit in the destination MAC marking group addresses
  localparam int DMAC_MC_BIT = 40;
  localparam logic [47:0] DMAC_BROADCAST = 48'hFFFFFFFFFFFF;

  // Register word offsets (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_LPORT = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;

  // Control and status register field positions
  localparam int CTRL_MASQ_BIT = 0;
  localparam int CTRL_CPU_BIT = 1;
  localparam int CTRL_VDEV_BIT = 2;
  localparam int CTRL_LBK3_BIT = 3;
  localparam int CTRL_GDEF_LSB = 4;
  localparam int STAT_MODE_LSB = 16;

  // Reset values
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [5:0] LPORT_RESET = 6'h00;

  typedef struct packed {
    logic [1:0] key_subtype_code;
    logic first_lookup;
    logic [5:0] phys_src_port;
    logic [5:0] hdr_src_port;
    logic injected;
    logic cpu_injected;
    logic from_loopback;
    logic [5:0] looped_port;
    logic [2:0] stage_action_code;
    logic [4:0] stage_point_code;
    logic [47:0] dmac;
    logic [1:0] next_index_control;
    logic [11:0] next_index_value;
    logic [11:0] service_index;
  } wckb_req_s;

  typedef struct packed {
    logic [1:0] key_subtype_code;
    logic first_lookup_flag;
    logic [5:0] logical_ingress_port;
    logic generic_index_from_service;
    logic [11:0] generic_index;
    logic [1:0] port_mask_mode;
    logic [52:0] ingress_port_bitmap;
    logic dest_multicast_flag;
    logic dest_broadcast_flag;
  } wckb_key_s;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } wckb_av_req_s;
endpackage

// >>> core/wckb_key_builder.sv
// Wide classifier key builder with its Avalon-MM configuration slave
module wckb_key_builder
  import wckb_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Avalon-MM slave
  input wire logic i_av_read,
  input wire logic i_av_write,
  input wire logic [AV_ADDR_W-1:0] i_av_address,
  input wire logic [31:0] i_av_writedata,
  output logic [31:0] o_av_readdata,
  output logic o_av_waitrequest,
  // Lookup request from the parser
  input wire logic i_req_valid,
  input wire wckb_req_s i_req,
  // Key to the match engine
  output logic o_key_valid,
  output wckb_key_s o_key
);

  typedef struct packed {
    logic masq_ena;
    logic cpu_ena;
    logic vdev_ena;
    logic lbk3_ena;
    logic [1:0] gidx_def_sel;
    logic [5:0] logical_port_number;
    logic waitreq;
    logic [31:0] rdata;
    logic key_valid;
    wckb_key_s key;
    logic [15:0] key_count;
  } wckb_state_s;

  wckb_state_s state_reg;
  wckb_state_s state_next;
  wckb_av_req_s av;

  assign av = '{read: i_av_read, write: i_av_write, address: i_av_address,
                writedata: i_av_writedata};

  always_comb begin
    logic masqueraded;
    logic is_special;
    logic [5:0] masq_port;
    logic [1:0] mode;
    logic [52:0] bitmap;
    logic [11:0] gidx;
    logic from_service;
    logic full_ll;
    logic bus_req;
    masqueraded = 1'b0;
    is_special = 1'b0;
    masq_port = '0;
    mode = MASK_MODE_DEFAULT;
    bitmap = '0;
    gidx = '0;
    from_service = 1'b0;
    full_ll = 1'b0;
    bus_req = 1'b0;
    state_next = state_reg;

    // Masquerade detection
    masqueraded = (i_req.injected && (i_req.hdr_src_port != i_req.phys_src_port)) ||
                  (i_req.stage_action_code == MASQ_INJECT_ACTION);
    masq_port = masqueraded ? i_req.hdr_src_port : i_req.phys_src_port;
    is_special = (i_req.cpu_injected && state_reg.cpu_ena) ||
                 (((i_req.phys_src_port == PORT_VDEV_ZERO) ||
                   (i_req.phys_src_port == PORT_VDEV_ONE)) && state_reg.vdev_ena) ||
                 (i_req.from_loopback && state_reg.lbk3_ena);

    // Highest qualifying mode first
    if (is_special) begin
      mode = MASK_MODE_SPECIAL;
    end else if (masqueraded && state_reg.masq_ena) begin
      mode = MASK_MODE_MASQ;
    end else if (i_req.from_loopback) begin
      mode = MASK_MODE_LOOPED;
    end else begin
      mode = MASK_MODE_DEFAULT;
    end

    unique case (mode)
      MASK_MODE_DEFAULT: begin
        bitmap = BITMAP_W'(1) << i_req.phys_src_port;
      end
      MASK_MODE_LOOPED: begin
        bitmap = BITMAP_W'(1) << i_req.looped_port;
      end
      MASK_MODE_MASQ: begin
        bitmap = BITMAP_W'(1) << masq_port;
      end
      MASK_MODE_SPECIAL: begin
        bitmap[BM_CPU_PORT_ZERO_BIT] = (i_req.phys_src_port == PORT_CPU_ZERO);
        bitmap[BM_CPU_PORT_ONE_BIT] = (i_req.phys_src_port == PORT_CPU_ONE);
        bitmap[BM_VD0_BIT] = (i_req.phys_src_port == PORT_VDEV_ZERO);
        bitmap[BM_VD1_BIT] = (i_req.phys_src_port == PORT_VDEV_ONE);
        bitmap[BM_SRC_LSB +: PORT_W] = masq_port;
        bitmap[BM_PT_LSB +: 5] = i_req.stage_point_code;
        bitmap[BM_ACT_LSB +: 3] = i_req.stage_action_code;
      end
    endcase

    // Generic index from the previous action, else the configured default
    if (i_req.next_index_control == NXT_CTRL_VALUE) begin
      gidx = i_req.next_index_value;
    end else if (i_req.next_index_control == NXT_CTRL_SERVICE) begin
      gidx = i_req.service_index;
      from_service = 1'b1;
    end else if (state_reg.gidx_def_sel == GIDX_DEF_LPORT) begin
      gidx = GIDX_W'(state_reg.logical_port_number);
    end else if (state_reg.gidx_def_sel == GIDX_DEF_MASQ) begin
      gidx = GIDX_W'(masq_port);
    end else begin
      gidx = '0;
    end

    // Key register, foreign fields zeroed
    full_ll = (i_req.key_subtype_code == KEY_FULL_LINK_LAYER);
    state_next.key_valid = i_req_valid;
    if (i_req_valid) begin
      state_next.key.key_subtype_code = i_req.key_subtype_code;
      state_next.key.first_lookup_flag = i_req.first_lookup;
      state_next.key.logical_ingress_port =
        full_ll ? state_reg.logical_port_number : '0;
      state_next.key.generic_index_from_service = full_ll ? 1'b0 : from_service;
      state_next.key.generic_index = full_ll ? '0 : gidx;
      state_next.key.port_mask_mode = mode;
      state_next.key.ingress_port_bitmap = bitmap;
      state_next.key.dest_multicast_flag = i_req.dmac[DMAC_MC_BIT];
      state_next.key.dest_broadcast_flag = (i_req.dmac == DMAC_BROADCAST);
      state_next.key_count = state_reg.key_count + 16'h0001;
    end

    // Bus slave: answer one cycle after the request appears
    bus_req = av.read || av.write;
    state_next.waitreq = !(bus_req && state_reg.waitreq);
    if (bus_req && state_reg.waitreq) begin
      state_next.rdata = '0;
      unique case (av.address)
        REG_CTRL: begin
          state_next.rdata[CTRL_MASQ_BIT] = state_reg.masq_ena;
          state_next.rdata[CTRL_CPU_BIT] = state_reg.cpu_ena;
          state_next.rdata[CTRL_VDEV_BIT] = state_reg.vdev_ena;
          state_next.rdata[CTRL_LBK3_BIT] = state_reg.lbk3_ena;
          state_next.rdata[CTRL_GDEF_LSB +: 2] = state_reg.gidx_def_sel;
        end
        REG_LPORT: begin
          state_next.rdata[PORT_W-1:0] = state_reg.logical_port_number;
        end
        REG_STATUS: begin
          state_next.rdata[15:0] = state_reg.key_count;
          state_next.rdata[STAT_MODE_LSB +: 2] = state_reg.key.port_mask_mode;
        end
        default: begin
          state_next.rdata = '0;
        end
      endcase
    end
    if (av.write && !state_reg.waitreq) begin
      if (av.address == REG_CTRL) begin
        state_next.masq_ena = av.writedata[CTRL_MASQ_BIT];
        state_next.cpu_ena = av.writedata[CTRL_CPU_BIT];
        state_next.vdev_ena = av.writedata[CTRL_VDEV_BIT];
        state_next.lbk3_ena = av.writedata[CTRL_LBK3_BIT];
        state_next.gidx_def_sel = av.writedata[CTRL_GDEF_LSB +: 2];
      end else if (av.address == REG_LPORT) begin
        state_next.logical_port_number = av.writedata[PORT_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg <= '0;
      state_reg.waitreq <= 1'b1;
      {state_reg.masq_ena, state_reg.cpu_ena, state_reg.vdev_ena,
       state_reg.lbk3_ena, state_reg.gidx_def_sel} <= CTRL_RESET;
      state_reg.logical_port_number <= LPORT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_av_readdata = state_reg.rdata;
  assign o_av_waitrequest = state_reg.waitreq;
  assign o_key_valid = state_reg.key_valid;
  assign o_key = state_reg.key;

endmodule

// >>> verification/wckb_key_builder_sva.sv
// Port checker for the key builder
module wckb_key_builder_chk
  import wckb_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Lookup and key
  input wire logic i_req_valid,
  input wire wckb_req_s i_req,
  input wire logic o_key_valid,
  input wire wckb_key_s o_key
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_subtype_copied: assert property (i_req_valid |=> o_key_valid
    && o_key.key_subtype_code == $past(i_req.key_subtype_code)) else $error("subtype wrong");
  a_first_flag: assert property (i_req_valid |=>
    o_key.first_lookup_flag == $past(i_req.first_lookup)) else $error("first flag wrong");
  a_no_stray_key: assert property (!i_req_valid |=> !o_key_valid) else $error("stray key");
  a_gidx_value: assert property (i_req_valid && i_req.key_subtype_code != 2'h0
    && i_req.next_index_control == NXT_CTRL_VALUE
    |=> o_key.generic_index == $past(i_req.next_index_value)) else $error("index wrong");
  a_service_flag: assert property (i_req_valid && i_req.key_subtype_code != 2'h0
    && i_req.next_index_control == NXT_CTRL_SERVICE |=> o_key.generic_index_from_service
    && o_key.generic_index == $past(i_req.service_index)) else $error("service wrong");
  a_full_no_gidx: assert property (i_req_valid && i_req.key_subtype_code == 2'h0
    |=> o_key.generic_index == 12'h000 && !o_key.generic_index_from_service)
    else $error("stale index");
  a_lport_foreign: assert property (i_req_valid && i_req.key_subtype_code != 2'h0
    |=> o_key.logical_ingress_port == 6'h00) else $error("stale port");
  a_reserved_zero: assert property (o_key_valid && o_key.port_mask_mode == 2'h3
    |-> !o_key.ingress_port_bitmap[52]) else $error("reserved bit set");
  a_mc_flag: assert property (i_req_valid |=>
    o_key.dest_multicast_flag == $past(i_req.dmac[DMAC_MC_BIT])) else $error("mc wrong");
  a_bc_flag: assert property (i_req_valid |=>
    o_key.dest_broadcast_flag == ($past(i_req.dmac) == DMAC_BROADCAST)) else $error("bc wrong");
endmodule

bind wckb_key_builder wckb_key_builder_chk wckb_key_builder_chk_i (.i_clk(i_clk),
  .i_rstn(i_rstn), .i_req_valid(i_req_valid), .i_req(i_req), .o_key_valid(o_key_valid),
  .o_key(o_key));

// >>> verification/wckb_far_end.sv
// Parser and match engine stand-in: issues lookups, captures keys
module wckb_far_end
  import wckb_pkg::*;
(
  // Clock and key
  input wire logic i_clk,
  input wire logic i_key_valid,
  input wire wckb_key_s i_key,
  // Lookup
  output logic o_req_valid,
  output wckb_req_s o_req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_req_valid = 1'b0;
    o_req = '0;
  end
  task automatic lookup(input wckb_req_s r, output logic v, output wckb_key_s k);
    @(posedge i_clk);
    o_req_valid <= 1'b1;
    o_req <= r;
    @(posedge i_clk);
    o_req_valid <= 1'b0;
    // Released fields show the inverse
    o_req <= ~r;
    #1;
    v = i_key_valid;
    k = i_key;
  endtask
endmodule

// >>> verification/wckb_key_builder_tb.sv
// Self-checking bench for the key builder
module wckb_key_builder_tb import wckb_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rstn, rd, wr, wait_rq, req_valid, key_valid;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  wckb_req_s req;
  wckb_key_s key, k;
  int errors = 0;
  int check_count = 0;
  wckb_key_builder wckb_key_builder_i (.i_clk(clk), .i_rstn(rstn), .i_av_read(rd),
    .i_av_write(wr), .i_av_address(addr), .i_av_writedata(wdata), .o_av_readdata(rdata),
    .o_av_waitrequest(wait_rq), .i_req_valid(req_valid), .i_req(req),
    .o_key_valid(key_valid), .o_key(key));
  wckb_far_end wckb_far_end_i (.i_clk(clk), .i_key_valid(key_valid), .i_key(key),
    .o_req_valid(req_valid), .o_req(req));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge clk); while (wait_rq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic send(input wckb_req_s r);
    logic v;
    wckb_far_end_i.lookup(r, v, k);
    chk(v, 1'b1);
  endtask
  function automatic wckb_req_s base(input logic [1:0] st);
    base = '0;
    base.key_subtype_code = st;
    base.phys_src_port = 6'h05;
    base.hdr_src_port = 6'h05;
    base.looped_port = 6'h09;
    base.next_index_value = 12'hABC;
    base.service_index = 12'h123;
  endfunction
  task automatic t_regs();
    logic [31:0] q;
    bus(1'b0, REG_CTRL, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b1, REG_LPORT, 32'h2A, q);
    bus(1'b0, REG_LPORT, 32'h0, q);
    chk(q, 32'h2A);
    bus(1'b1, 4'hC, 32'hFFFFFFFF, q);
    bus(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_sub();
    wckb_req_s r;
    for (int i = 0; i < 4; i++) begin
      r = base(2'(i));
      r.first_lookup = i[0];
      r.next_index_control = NXT_CTRL_VALUE;
      send(r);
      chk(k.key_subtype_code, i);
      chk(k.first_lookup_flag, i[0]);
      chk(k.logical_ingress_port, i == 0 ? 6'h2A : 6'h00);
      chk(k.generic_index, i == 0 ? 12'h000 : 12'hABC);
    end
    $display("test subtypes done");
  endtask
  task automatic t_gidx();
    logic [11:0] e[3] = '{12'h000, 12'h02A, 12'h007};
    wckb_req_s r;
    logic [31:0] q;
    r = base(2'h2);
    r.injected = 1'b1;
    r.hdr_src_port = 6'h07;
    for (int j = 0; j < 3; j++) begin
      bus(1'b1, REG_CTRL, 32'(j) << 4, q);
      send(r);
      chk(k.generic_index, e[j]);
    end
    r.next_index_control = NXT_CTRL_SERVICE;
    send(r);
    chk(k.generic_index_from_service, 1'b1);
    chk(k.generic_index, 12'h123);
    $display("test index done");
  endtask
  task automatic t_mode(input logic [5:0] c, input wckb_req_s r, input logic [1:0] m,
      input logic [52:0] b);
    logic [31:0] q;
    bus(1'b1, REG_CTRL, {26'h0, c}, q);
    send(r);
    chk(k.port_mask_mode, m);
    chk(k.ingress_port_bitmap, b);
  endtask
  task automatic t_mask();
    wckb_req_s r;
    logic [31:0] q;
    r = base(2'h1);
    t_mode(6'h00, r, MASK_MODE_DEFAULT, 53'h20);
    r.from_loopback = 1'b1;
    t_mode(6'h00, r, MASK_MODE_LOOPED, 53'h200);
    t_mode(6'h08, r, MASK_MODE_SPECIAL, 53'h50);
    r = base(2'h1);
    r.hdr_src_port = 6'h0C;
    r.stage_action_code = MASQ_INJECT_ACTION;
    t_mode(6'h01, r, MASK_MODE_MASQ, 53'h1000);
    r.injected = 1'b1;
    r.cpu_injected = 1'b1;
    r.phys_src_port = PORT_CPU_ONE;
    r.stage_point_code = 5'h15;
    t_mode(6'h0F, r, MASK_MODE_SPECIAL, 53'hB5000000000C2);
    r = base(2'h1);
    r.phys_src_port = PORT_VDEV_ZERO;
    r.hdr_src_port = PORT_VDEV_ZERO;
    t_mode(6'h04, r, MASK_MODE_SPECIAL, 53'h374);
    // Fourteen keys so far, the last one in mode 3
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk(q, 32'h0003000E);
    $display("test mask done");
  endtask
  task automatic t_dmac();
    logic [47:0] d[4] = '{48'h010000000000, 48'hFFFFFFFFFFFF, 48'hFFFFFFFFFFFE,
      48'hFEFFFFFFFFFF};
    wckb_req_s r;
    r = base(2'h3);
    for (int j = 0; j < 4; j++) begin
      r.dmac = d[j];
      send(r);
      chk(k.dest_multicast_flag, j < 3);
      chk(k.dest_broadcast_flag, j == 1);
    end
    $display("test dmac done");
  endtask
  task automatic t_reset();
    logic [31:0] q;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk(wait_rq, 1'b1);
    chk(rdata, 32'h0);
    rstn <= 1'b1;
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b0, REG_LPORT, 32'h0, q);
    chk(q, 32'h0);
    $display("test reset done");
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end
  initial begin
    rstn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_sub();
    t_gidx();
    t_mask();
    t_dmac();
    t_reset();
    final_report();
  end
endmodule
